// ===== core/dcrc_pkg.sv
package dcrc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int RST_PULSE_NS = 100;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_APP_CAUSE = 12'h000;
  localparam logic [11:0] OFS_NET_CAUSE = 12'h004;
  localparam logic [11:0] OFS_HOLD_OFF = 12'h008;
  localparam logic [11:0] OFS_APP_RSTCTL = 12'h00C;
  localparam logic [11:0] OFS_NET_RSTCTL = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int CAUSE_W = 10;
  localparam int CB_POR = 0;
  localparam int CB_PIN = 1;
  localparam int CB_DROP = 2;
  localparam int CB_WAKE = 3;
  localparam int CB_SOFT = 4;
  localparam int CB_DBGPORT = 5;
  localparam int CB_LOCKUP = 6;
  localparam int CB_NET_CORE_HOLD_OFF = 7;
  localparam int CB_NET_SOFT = 8;
  localparam int CB_NET_LOCKUP = 9;
  localparam int SYSREQ_BIT = 0;
  localparam int HOLD_BIT = 0;
  localparam logic [9:0] CAUSE_RST = 10'h001;
  localparam logic HOLD_RST = 1'b1;

  // ****************************************************************
  // Pin synchroniser lanes
  // ****************************************************************
  localparam int SY_N = 6;
  localparam int SY_POR_OK = 0;
  localparam int SY_REG_OK = 1;
  localparam int SY_DROP = 2;
  localparam int SY_PIN_N = 3;
  localparam int SY_WAKE = 4;
  localparam int SY_DBGREQ = 5;
  localparam logic [5:0] SYNC_RST = 6'h08;

  typedef enum logic [1:0] {
    ST_SYS_HOLD = 2'b00,
    ST_APP_PULSE = 2'b01,
    ST_RUN = 2'b10
  } dcrc_state_t;

endpackage

// ===== core/dcrc_top.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcrc_top
#(
  parameter int PULSE_CYC = dcrc_pkg::RST_PULSE_CYC
)
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcrc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitor and pins
  input wire logic supply_ok,
  input wire logic regulators_ok,
  input wire logic supply_drop_reset,
  input wire logic reset_pin_n,
  input wire logic sysoff_wakeup,
  // Debug side
  input wire logic debug_mode,
  input wire logic debug_control_port_req,
  // Core events
  input wire logic app_lockup,
  input wire logic net_lockup,
  // Reset outputs
  output logic app_rst_n,
  output logic net_rst_n,
  output logic debug_access_port_rst_n
);
  import dcrc_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [9:0] cause_upd(input logic [9:0] old_v,
                                          input logic [9:0] clr_v,
                                          input logic [9:0] set_v);
    cause_upd = (old_v & ~clr_v) | set_v;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == OFS_APP_CAUSE) || (a == OFS_NET_CAUSE) ||
                (a == OFS_HOLD_OFF) || (a == OFS_APP_RSTCTL) ||
                (a == OFS_NET_RSTCTL) || (a == OFS_STATUS);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [SY_N-1:0] sync1_reg;
  logic [SY_N-1:0] sync2_reg;
  logic dbg_mode1_reg;
  logic dbg_mode2_reg;
  dcrc_state_t state_reg;
  dcrc_state_t state_next;
  logic [CNT_W-1:0] app_cnt_reg;
  logic [CNT_W-1:0] net_cnt_reg;
  logic [1:0] app_rel_reg;
  logic [1:0] net_rel_reg;
  logic dbg_rst_n_reg;
  logic hold_off_reg;
  logic [9:0] app_cause_reg;
  logic [9:0] net_cause_reg;
  logic [31:0] prdata_reg;
  logic wr;
  logic wr_hold;
  logic app_sw_req;
  logic net_sw_req;
  logic src_por;
  logic src_pin;
  logic src_drop;
  logic src_wake;
  logic sys_level;
  logic sys_any;
  logic app_src;
  logic net_src;
  logic net_hold;
  logic app_lock_ok;
  logic net_lock_ok;
  logic [9:0] app_set;
  logic [9:0] net_set;
  logic [9:0] app_clr;
  logic [9:0] net_clr;
  logic [CNT_W-1:0] pulse_load;

  assign pulse_load = CNT_W'(PULSE_CYC);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      dbg_mode1_reg <= 1'b0;
      dbg_mode2_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync1_reg <= {debug_control_port_req, sysoff_wakeup, reset_pin_n,
                    supply_drop_reset, regulators_ok, supply_ok};
      sync2_reg <= sync1_reg;
      dbg_mode1_reg <= debug_mode;
      dbg_mode2_reg <= dbg_mode1_reg;
    end

  // ****************************************************************
  // Source decode
  // ****************************************************************
  assign wr = psel && penable && pwrite && ce;
  assign wr_hold = wr && (paddr == OFS_HOLD_OFF);
  assign app_sw_req = wr && (paddr == OFS_APP_RSTCTL) &&
                      pwdata[SYSREQ_BIT];
  assign net_sw_req = wr && (paddr == OFS_NET_RSTCTL) &&
                      pwdata[SYSREQ_BIT];
  assign src_por = !sync2_reg[SY_POR_OK] || !sync2_reg[SY_REG_OK];
  assign src_pin = !sync2_reg[SY_PIN_N];
  assign src_drop = sync2_reg[SY_DROP];
  assign src_wake = sync2_reg[SY_WAKE];
  assign sys_level = src_por || src_pin || src_drop;
  assign sys_any = sys_level || src_wake;
  // Lockup does not reset while debugging
  assign app_lock_ok = app_lockup && !dbg_mode2_reg;
  assign net_lock_ok = net_lockup && !dbg_mode2_reg;
  assign app_src = app_sw_req || sync2_reg[SY_DBGREQ] ||
                   app_lock_ok;
  assign net_src = net_sw_req || net_lock_ok;

  // ****************************************************************
  // Application core sequencing
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_SYS_HOLD:
        if (!sys_any)
          state_next = ST_APP_PULSE;
      ST_APP_PULSE:
        if (sys_any)
          state_next = ST_SYS_HOLD;
        else if (app_cnt_reg == '0)
          state_next = ST_RUN;
      ST_RUN:
        if (sys_any)
          state_next = ST_SYS_HOLD;
        else if (app_src)
          state_next = ST_APP_PULSE;
      default:
        state_next = ST_SYS_HOLD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      state_reg <= ST_SYS_HOLD;
    else if (ce)
      state_reg <= state_next;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      app_cnt_reg <= '0;
    else if (ce)
    begin
      if (state_next == ST_APP_PULSE && state_reg != ST_APP_PULSE)
        app_cnt_reg <= pulse_load;
      else if (app_cnt_reg != '0)
        app_cnt_reg <= app_cnt_reg - CNT_W'(1);
    end

  // ****************************************************************
  // Network core hold-off and local reset
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hold_off_reg <= HOLD_RST;
    else if (ce)
    begin
      if (state_reg != ST_RUN)
        hold_off_reg <= 1'b1;
      else if (wr_hold)
        hold_off_reg <= pwdata[HOLD_BIT];
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      net_cnt_reg <= '0;
    else if (ce)
    begin
      if (net_src && state_reg == ST_RUN && !hold_off_reg)
        net_cnt_reg <= pulse_load;
      else if (net_cnt_reg != '0)
        net_cnt_reg <= net_cnt_reg - CNT_W'(1);
    end

  assign net_hold = hold_off_reg || (net_cnt_reg != '0) ||
                    (state_reg != ST_RUN);

  // ****************************************************************
  // Reset release synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      app_rel_reg <= 2'h0;
    else if (ce)
    begin
      if (state_reg != ST_RUN)
        app_rel_reg <= 2'h0;
      else
        app_rel_reg <= {app_rel_reg[0], 1'b1};
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      net_rel_reg <= 2'h0;
    else if (ce)
    begin
      if (net_hold)
        net_rel_reg <= 2'h0;
      else
        net_rel_reg <= {net_rel_reg[0], 1'b1};
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dbg_rst_n_reg <= 1'b0;
    else if (ce)
      dbg_rst_n_reg <= !(sys_level || (src_wake && !dbg_mode2_reg));

  assign app_rst_n = app_rel_reg[1];
  assign net_rst_n = net_rel_reg[1];
  assign debug_access_port_rst_n = dbg_rst_n_reg;

  // ****************************************************************
  // Reset cause registers
  // ****************************************************************
  always_comb
  begin
    app_set = '0;
    app_set[CB_POR] = src_por;
    app_set[CB_PIN] = src_pin;
    app_set[CB_DROP] = src_drop;
    app_set[CB_WAKE] = src_wake;
    app_set[CB_SOFT] = app_sw_req;
    app_set[CB_DBGPORT] = sync2_reg[SY_DBGREQ];
    app_set[CB_LOCKUP] = app_lock_ok;
    net_set = app_set;
    net_set[CB_NET_CORE_HOLD_OFF] = (state_reg != ST_RUN) ||
                           (wr_hold && pwdata[HOLD_BIT]);
    net_set[CB_NET_SOFT] = net_sw_req;
    net_set[CB_NET_LOCKUP] = net_lock_ok;
  end

  assign app_clr = (wr && paddr == OFS_APP_CAUSE) ? pwdata[9:0] : '0;
  assign net_clr = (wr && paddr == OFS_NET_CAUSE) ? pwdata[9:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      app_cause_reg <= CAUSE_RST;
    else if (ce)
      app_cause_reg <= cause_upd(app_cause_reg, app_clr, app_set);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      net_cause_reg <= CAUSE_RST;
    else if (ce)
      net_cause_reg <= cause_upd(net_cause_reg, net_clr, net_set);

  // ****************************************************************
  // APB read path
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_reg <= '0;
    else if (ce && psel && !penable)
    begin
      case (paddr)
        OFS_APP_CAUSE: prdata_reg <= {22'h000000, app_cause_reg};
        OFS_NET_CAUSE: prdata_reg <= {22'h000000, net_cause_reg};
        OFS_HOLD_OFF: prdata_reg <= {31'h00000000, hold_off_reg};
        OFS_STATUS: prdata_reg <= {28'h0000000, net_rst_n, app_rst_n,
                                   state_reg};
        default: prdata_reg <= '0;
      endcase
    end

  assign prdata = prdata_reg;
  assign pready = ce;
  assign pslverr = psel && penable && !is_mapped(paddr);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_app_run2;
    (ce && state_reg == ST_RUN) [*2];
  endsequence

  sequence s_app_soft;
    ce && state_reg == ST_RUN && app_src && !sys_any;
  endsequence

  a_sys_source_hold: assert property (
    (ce && sys_any) |=> state_reg == ST_SYS_HOLD)
    else $error("system source did not hold the device");
  a_app_reset_asserted: assert property (
    (ce && state_reg != ST_RUN) |=> !app_rst_n)
    else $error("app reset not asserted");
  a_app_release_two: assert property (
    s_app_run2 |=> app_rst_n)
    else $error("app reset not released after two flops");
  a_net_held: assert property (
    (ce && net_hold) |=> !net_rst_n)
    else $error("net core left reset while held");
  a_hold_off_forced: assert property (
    (ce && state_reg != ST_RUN) |=>
      hold_off_reg && net_cause_reg[CB_NET_CORE_HOLD_OFF])
    else $error("app reset did not force the net core off");
  a_hold_off_kept: assert property (
    (ce && hold_off_reg && !wr_hold) |=> hold_off_reg)
    else $error("hold-off dropped without software");
  a_app_soft_pulse: assert property (
    s_app_soft |=> state_reg == ST_APP_PULSE ##1 !net_rst_n)
    else $error("app soft reset not applied");
  a_net_soft_local: assert property (
    (ce && state_reg == ST_RUN && net_src && !app_src && !sys_any &&
     !hold_off_reg) |=> state_reg == ST_RUN && net_cnt_reg != '0)
    else $error("net soft reset touched the app core");
  a_wake_keeps_debug: assert property (
    (ce && src_wake && dbg_mode2_reg && !sys_level) |=>
      debug_access_port_rst_n)
    else $error("debug port reset by wakeup in debug mode");
  a_cause_both: assert property (
    (ce && src_pin) |=> app_cause_reg[CB_PIN] && net_cause_reg[CB_PIN])
    else $error("pin reset cause not recorded");

endmodule
`default_nettype wire

// ===== verif/dcrc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcrc_core_model
(
  // Clock
  input wire logic pclk,
  // Commands from the bench
  input wire logic app_lock_cmd,
  input wire logic net_lock_cmd,
  input wire logic dbg_cmd,
  // Resets seen by the cores
  input wire logic app_rst_n,
  input wire logic net_rst_n,
  // Core and debug requests
  output logic app_lockup,
  output logic net_lockup,
  output logic debug_control_port_req
);
  initial
  begin
    app_lockup = 1'b0;
    net_lockup = 1'b0;
    debug_control_port_req = 1'b0;
  end

  // A core in reset cannot lock up; a locked core stays stuck until reset
  always @(posedge pclk)
  begin
    app_lockup <= app_rst_n & (app_lockup | app_lock_cmd);
    net_lockup <= net_rst_n & (net_lockup | net_lock_cmd);
    // Request level held until the app core is seen in reset
    debug_control_port_req <= app_rst_n &
                              (debug_control_port_req | dbg_cmd);
  end
endmodule
`default_nettype wire

// ===== verif/dual_core_reset_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_core_reset_control_tb_top;
  import dcrc_pkg::*;
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic supply_ok, regulators_ok, supply_drop_reset, reset_pin_n;
  logic sysoff_wakeup, debug_mode, app_lockup, net_lockup, dbg_req;
  logic app_lock_cmd, net_lock_cmd, dbg_cmd, net_hi, app_lo, dbg_lo;
  logic app_rst_n, net_rst_n, debug_access_port_rst_n;
  int mismatches = 0;
  int cmp_count = 0;
  int k;

  always #2 pclk = ~pclk;

  dcrc_top #(.PULSE_CYC(2)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(supply_ok), .regulators_ok(regulators_ok),
    .supply_drop_reset(supply_drop_reset), .reset_pin_n(reset_pin_n),
    .sysoff_wakeup(sysoff_wakeup), .debug_mode(debug_mode),
    .debug_control_port_req(dbg_req), .app_lockup(app_lockup),
    .net_lockup(net_lockup), .app_rst_n(app_rst_n), .net_rst_n(net_rst_n),
    .debug_access_port_rst_n(debug_access_port_rst_n));

  dcrc_core_model u_cores (.pclk(pclk), .app_lock_cmd(app_lock_cmd),
    .net_lock_cmd(net_lock_cmd), .dbg_cmd(dbg_cmd), .app_rst_n(app_rst_n),
    .net_rst_n(net_rst_n), .app_lockup(app_lockup), .net_lockup(net_lockup),
    .debug_control_port_req(dbg_req));

  // Settled-value watchers for hold checks
  always @(negedge pclk)
  begin
    net_hi = net_hi | (net_rst_n === 1'b1);
    app_lo = app_lo | (app_rst_n !== 1'b1);
    dbg_lo = dbg_lo | (debug_access_port_rst_n !== 1'b1);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_bit(input logic [11:0] a, input int b, input logic v);
    apb(1'b0, a, 32'h0);
    check({31'h0, q[b]}, {31'h0, v});
  endtask

  task automatic wait_rst(input int w, input logic v);
    int n;
    n = 0;
    while (((w == 0) ? app_rst_n : net_rst_n) !== v && n < 80)
    begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, (w == 0) ? app_rst_n : net_rst_n}, {31'h0, v});
  endtask

  function automatic int cause_of(input int s);
    case (s)
      0: return CB_PIN;
      1: return CB_DROP;
      2, 3: return CB_WAKE;
      default: return CB_POR;
    endcase
  endfunction

  task automatic set_src(input int s, input logic v);
    case (s)
      0: reset_pin_n <= !v;
      1: supply_drop_reset <= v;
      2, 3: sysoff_wakeup <= v;
      4: supply_ok <= !v;
      default: regulators_ok <= !v;
    endcase
  endtask

  task automatic run_net;
    apb(1'b1, OFS_HOLD_OFF, 32'h0);
    wait_rst(1, 1'b1);
    apb(1'b1, OFS_APP_CAUSE, $urandom | 32'h3FF);
    apb(1'b1, OFS_NET_CAUSE, $urandom | 32'h3FF);
  endtask

  task automatic sys_event(input int s);
    debug_mode <= (s == 3);
    run_net();
    dbg_lo = 1'b0;
    set_src(s, 1'b1);
    wait_rst(0, 1'b0);
    wait_rst(1, 1'b0);
    repeat ($urandom_range(3, 8)) @(posedge pclk);
    set_src(s, 1'b0);
    wait_rst(0, 1'b1);
    net_hi = 1'b0;
    repeat (20) @(posedge pclk);
    check({31'h0, net_hi}, 32'h0);
    check({31'h0, dbg_lo}, {31'h0, s != 3});
    rd_bit(OFS_HOLD_OFF, HOLD_BIT, 1'b1);
    rd_bit(OFS_APP_CAUSE, cause_of(s), 1'b1);
    rd_bit(OFS_NET_CAUSE, cause_of(s), 1'b1);
    rd_bit(OFS_NET_CAUSE, CB_NET_CORE_HOLD_OFF, 1'b1);
  endtask

  task automatic app_local(input int t);
    run_net();
    if (t == 0)
      apb(1'b1, OFS_APP_RSTCTL, 32'h1 << SYSREQ_BIT);
    else if (t == 1)
      dbg_cmd <= 1'b1;
    else
      app_lock_cmd <= 1'b1;
    wait_rst(0, 1'b0);
    wait_rst(1, 1'b0);
    dbg_cmd <= 1'b0;
    app_lock_cmd <= 1'b0;
    // Clock enable low must freeze the reset pulse
    if (t == 0)
    begin
      ce <= 1'b0;
      repeat ($urandom_range(20, 40)) @(posedge pclk);
      check({31'h0, app_rst_n}, 32'h0);
      ce <= 1'b1;
    end
    wait_rst(0, 1'b1);
    net_hi = 1'b0;
    repeat (20) @(posedge pclk);
    check({31'h0, net_hi}, 32'h0);
    k = (t == 0) ? CB_SOFT : (t == 1) ? CB_DBGPORT : CB_LOCKUP;
    rd_bit(OFS_APP_CAUSE, k, 1'b1);
    rd_bit(OFS_NET_CAUSE, k, 1'b1);
    rd_bit(OFS_NET_CAUSE, CB_NET_CORE_HOLD_OFF, 1'b1);
  endtask

  task automatic net_local(input int t);
    run_net();
    app_lo = 1'b0;
    if (t == 0)
      apb(1'b1, OFS_NET_RSTCTL, 32'h1 << SYSREQ_BIT);
    else
      net_lock_cmd <= 1'b1;
    wait_rst(1, 1'b0);
    net_lock_cmd <= 1'b0;
    wait_rst(1, 1'b1);
    check({31'h0, app_lo}, 32'h0);
    k = (t == 0) ? CB_NET_SOFT : CB_NET_LOCKUP;
    rd_bit(OFS_NET_CAUSE, k, 1'b1);
    rd_bit(OFS_APP_CAUSE, k, 1'b0);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, supply_ok, supply_drop_reset} = 6'h00;
    {sysoff_wakeup, debug_mode, app_lock_cmd, net_lock_cmd} = 4'h0;
    {ce, regulators_ok, reset_pin_n, dbg_cmd} = 4'hE;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(34186));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat ($urandom_range(5, 15)) @(posedge pclk);
    check({31'h0, app_rst_n}, 32'h0);
    rd_bit(OFS_HOLD_OFF, HOLD_BIT, HOLD_RST);
    apb(1'b0, OFS_APP_CAUSE, 32'h0);
    check(q, {22'h0, CAUSE_RST});
    supply_ok <= 1'b1;
    net_hi = 1'b0;
    wait_rst(0, 1'b1);
    repeat (20) @(posedge pclk);
    check({31'h0, net_hi}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q & 32'hF, {28'h0, 2'b01, ST_RUN});
    apb(1'b0, OFS_APP_RSTCTL, 32'h0);
    check(q, 32'h0);
    apb(1'b1, 12'h020, $urandom);
    check({31'h0, slv}, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    check(q, 32'h0);
    k = $urandom_range(0, 5);
    for (int i = 0; i < 6; i++)
      sys_event((k + i) % 6);
    debug_mode <= 1'b0;
    for (int t = 0; t < 3; t++)
      app_local(t);
    for (int t = 0; t < 2; t++)
      net_local(t);
    give_verdict();
  end
endmodule
`default_nettype wire
